// file: inc/msp_pkg.sv
// Shared constants and types of the multidrop serial port
package msp_pkg;
    // Core clock and oversampling
    localparam int unsigned CLK_HZ    = 250_000_000;
    localparam int unsigned OVS       = 16;
    localparam int unsigned BAUD_SLOW = 9600;
    localparam int unsigned BAUD_MID  = 19200;
    localparam int unsigned BAUD_FAST = 38400;
    localparam logic [10:0] DIV_SLOW  = 11'(CLK_HZ / (BAUD_SLOW * OVS) - 1);
    localparam logic [10:0] DIV_MID   = 11'(CLK_HZ / (BAUD_MID * OVS) - 1);
    localparam logic [10:0] DIV_FAST  = 11'(CLK_HZ / (BAUD_FAST * OVS) - 1);
    localparam logic [3:0]  OVS_LAST  = 4'hf;
    localparam logic [3:0]  OVS_MID   = 4'h7;

    // Switch bank field positions (1 = switch on)
    localparam int SW_DATA7   = 0;
    localparam int SW_NOPAR   = 1;
    localparam int SW_ODD     = 2;
    localparam int SW_STOP1   = 3;
    localparam int SW_RATE_LO = 4;
    localparam int SW_RATE_HI = 5;

    // Register map, byte addresses
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_TXDATA = 12'h008;
    localparam logic [11:0] REG_RXDATA = 12'h00c;
    localparam logic [11:0] REG_CONFIG = 12'h010;

    // Control and status field positions
    localparam int CTRL_RX_EN  = 0;
    localparam int CTRL_TX_EN  = 1;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam int ST_TX_BUSY  = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_PAR_ERR  = 2;
    localparam int ST_FRM_ERR  = 3;
    localparam int ST_OVR_ERR  = 4;
    localparam int ST_BCC_ERR  = 5;
    localparam int ST_BCC_OK   = 6;
    localparam int CFG_STATION = 8;
    localparam int CFG_PEND_SW = 16;
    localparam int CFG_PEND_ST = 24;
    localparam int CFG_RESTART = 31;

    // Message control bytes
    localparam logic [7:0] CH_ACK = 8'h06;
    localparam logic [7:0] CH_NAK = 8'h15;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;

    // Switch sampling delay after reset release
    localparam logic [1:0] CAP_WAIT = 2'h3;

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} msp_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} msp_rx_e;
    typedef enum logic [1:0] {MSG_NONE, MSG_BODY, MSG_BCC} msp_msg_e;
endpackage

// file: rtl/msp_baud_gen.sv
// Oversampling tick divider for the serial bit rate
`timescale 1ns/10ps
module msp_baud_gen
    import msp_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] rate_sel,
    output logic            tick
);
    typedef struct packed {
        logic [10:0] cnt;
        logic        tick;
    } msp_baud_s;

    msp_baud_s st;
    msp_baud_s next_st;
    logic [10:0] div;

    always_comb begin
        unique case (rate_sel)
            2'b10:   div = DIV_FAST;
            2'b01:   div = DIV_MID;
            default: div = DIV_SLOW;
        endcase
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= div) begin
            next_st.cnt  = 11'h000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 11'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

// file: rtl/msp_serial_port.sv
// Multidrop serial port: framing, block check and APB registers
// Contract
// - Independent async transmit and receive paths
// - Switch 1 off eight bits, on seven
// - Switch 2 off adds parity bit
// - Switch 3 off even, on odd parity
// - Switch 4 off two stops, on one
// - Switches 5/6 pick 9600/19200/38400 bps
// - Switch changes apply only after reset
// - Station number 00 to 15, strapped
// - ACK 06, NAK 15, STX 02, ETX 03
// - Block check is XOR after STX through ETX
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module msp_serial_port
    import msp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [5:0]  serial_format_switch_bank,
    input  wire logic [3:0]  station_number,
    input  wire logic        ser_rx,
    output logic             ser_tx,
    output logic             ser_de
);
    typedef struct packed {
        logic        rx_s1;
        logic        rx_s2;
        logic [5:0]  sw_s1;
        logic [5:0]  sw_s2;
        logic [3:0]  st_s1;
        logic [3:0]  st_s2;
        logic [1:0]  cap_cnt;
        logic        loaded;
        logic [5:0]  sw_act;
        logic [3:0]  st_act;
        logic [1:0]  ctrl;
        msp_tx_e     tx_st;
        logic [3:0]  tx_tick;
        logic [2:0]  tx_bit;
        logic [7:0]  tx_shift;
        logic        tx_par;
        logic        tx_stop2;
        logic        tx_line;
        logic        tx_de;
        logic [7:0]  tx_bcc;
        logic        tx_msg;
        msp_rx_e     rx_st;
        logic [3:0]  rx_tick;
        logic [2:0]  rx_bit;
        logic [7:0]  rx_shift;
        logic        rx_pbad;
        logic [7:0]  rx_data;
        logic        rx_valid;
        logic        par_err;
        logic        frm_err;
        logic        ovr_err;
        logic        bcc_err;
        logic        bcc_ok;
        logic [7:0]  rx_bcc;
        msp_msg_e    rx_msg;
        logic [31:0] rdata;
        logic        err;
    } msp_port_s;

    msp_port_s st;
    msp_port_s next_st;
    logic      tick;

    // Parity bit for a character of the active length
    function automatic logic frame_parity(input logic [7:0] d, input logic d7, input logic odd);
        logic [7:0] m;
        m = d7 ? {1'b0, d[6:0]} : d;
        return (^m) ^ odd;
    endfunction

    function automatic logic reg_known(input logic [11:0] a);
        return a == REG_CTRL || a == REG_STATUS || a == REG_TXDATA ||
               a == REG_RXDATA || a == REG_CONFIG;
    endfunction

    msp_baud_gen u_baud (
        .core_clk (core_clk),
        .rst      (rst),
        .rate_sel ({st.sw_act[SW_RATE_LO], st.sw_act[SW_RATE_HI]}),
        .tick     (tick)
    );

    logic       data7;
    logic       par_en;
    logic       odd;
    logic [2:0] last_bit;
    logic       setup;
    logic       access;
    logic       wr;
    logic       rd_rx;
    logic       tx_go;
    logic [7:0] tx_byte;
    logic [7:0] rx_full;
    logic       deliver;
    logic [7:0] w1c;
    logic [7:0] status;

    always_comb begin
        data7    = st.sw_act[SW_DATA7];
        par_en   = !st.sw_act[SW_NOPAR];
        odd      = st.sw_act[SW_ODD];
        last_bit = data7 ? 3'h6 : 3'h7;
        setup    = psel && !penable;
        access   = psel && penable;
        wr       = access && pwrite && reg_known(paddr);
        rd_rx    = access && !pwrite && paddr == REG_RXDATA;
        tx_byte  = data7 ? {1'b0, pwdata[6:0]} : pwdata[7:0];
        tx_go    = wr && paddr == REG_TXDATA && st.tx_st == TX_IDLE &&
                   st.ctrl[CTRL_TX_EN] && st.loaded;
        w1c      = (wr && paddr == REG_STATUS) ? pwdata[7:0] : 8'h00;
        rx_full  = {st.rx_s2, st.rx_shift[7:1]};
        deliver  = 1'b0;
        status   = {1'b0, st.bcc_ok, st.bcc_err, st.ovr_err, st.frm_err, st.par_err,
                    st.rx_valid, st.tx_st != TX_IDLE};

        next_st = st;
        // Synchronisers: second stage alone feeds the logic
        next_st.rx_s1 = ser_rx;
        next_st.rx_s2 = st.rx_s1;
        next_st.sw_s1 = serial_format_switch_bank;
        next_st.sw_s2 = st.sw_s1;
        next_st.st_s1 = station_number;
        next_st.st_s2 = st.st_s1;

        // Settings are taken once after reset, never while running
        if (!st.loaded) begin
            if (st.cap_cnt == CAP_WAIT) begin
                next_st.loaded = 1'b1;
                next_st.sw_act = st.sw_s2;
                next_st.st_act = st.st_s2;
            end else begin
                next_st.cap_cnt = st.cap_cnt + 2'h1;
            end
        end

        if (wr && paddr == REG_CTRL) begin
            next_st.ctrl = pwdata[1:0];
        end

        // Transmit path, runs regardless of receive
        if (tx_go) begin
            next_st.tx_st    = TX_START;
            next_st.tx_shift = tx_byte;
            next_st.tx_par   = frame_parity(tx_byte, data7, odd);
            next_st.tx_stop2 = !st.sw_act[SW_STOP1];
            next_st.tx_tick  = 4'h0;
            next_st.tx_line  = 1'b0;
            next_st.tx_de    = 1'b1;
            // Running check over a message for software to append
            if (tx_byte == CH_STX) begin
                next_st.tx_bcc = 8'h00;
                next_st.tx_msg = 1'b1;
            end else if (st.tx_msg) begin
                next_st.tx_bcc = st.tx_bcc ^ tx_byte;
                next_st.tx_msg = tx_byte != CH_ETX;
            end
        end else if (tick && st.tx_st != TX_IDLE) begin
            next_st.tx_tick = st.tx_tick + 4'h1;
            if (st.tx_tick == OVS_LAST) begin
                unique case (st.tx_st)
                    TX_START: begin
                        next_st.tx_st   = TX_DATA;
                        next_st.tx_bit  = 3'h0;
                        next_st.tx_line = st.tx_shift[0];
                    end
                    TX_DATA: begin
                        if (st.tx_bit == last_bit) begin
                            next_st.tx_st   = par_en ? TX_PAR : TX_STOP;
                            next_st.tx_line = par_en ? st.tx_par : 1'b1;
                        end else begin
                            next_st.tx_bit   = st.tx_bit + 3'h1;
                            next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
                            next_st.tx_line  = st.tx_shift[1];
                        end
                    end
                    TX_PAR: begin
                        next_st.tx_st   = TX_STOP;
                        next_st.tx_line = 1'b1;
                    end
                    TX_STOP: begin
                        if (st.tx_stop2) begin
                            next_st.tx_stop2 = 1'b0;
                        end else begin
                            next_st.tx_st = TX_IDLE;
                            next_st.tx_de = 1'b0;
                        end
                    end
                    TX_IDLE: begin
                        next_st.tx_line = 1'b1;
                    end
                endcase
            end
        end

        // Receive path, samples each bit at its middle
        if (st.rx_st == RX_IDLE) begin
            if (!st.rx_s2 && st.ctrl[CTRL_RX_EN] && st.loaded) begin
                next_st.rx_st   = RX_START;
                next_st.rx_tick = 4'h0;
            end
        end else if (tick) begin
            next_st.rx_tick = st.rx_tick + 4'h1;
            unique case (st.rx_st)
                RX_START: begin
                    if (st.rx_tick == OVS_MID) begin
                        next_st.rx_tick = 4'h0;
                        next_st.rx_bit  = 3'h0;
                        // A short low pulse is noise, not a start bit
                        next_st.rx_st   = st.rx_s2 ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (st.rx_tick == OVS_LAST) begin
                        next_st.rx_shift = rx_full;
                        next_st.rx_bit   = st.rx_bit + 3'h1;
                        if (st.rx_bit == last_bit) begin
                            // Seven-bit characters sit in the low bits
                            next_st.rx_shift = data7 ? {1'b0, rx_full[7:1]} : rx_full;
                            next_st.rx_st    = par_en ? RX_PAR : RX_STOP;
                            next_st.rx_pbad  = 1'b0;
                        end
                    end
                end
                RX_PAR: begin
                    if (st.rx_tick == OVS_LAST) begin
                        next_st.rx_pbad = frame_parity(st.rx_shift, data7, odd) != st.rx_s2;
                        next_st.rx_st   = RX_STOP;
                    end
                end
                RX_STOP: begin
                    // Only the first stop bit is checked; a second one reads as idle
                    if (st.rx_tick == OVS_LAST) begin
                        next_st.rx_st = RX_IDLE;
                        deliver       = 1'b1;
                    end
                end
                RX_IDLE: begin
                    next_st.rx_tick = 4'h0;
                end
            endcase
        end

        // Status flags: hardware set wins over software clear
        next_st.rx_valid = (st.rx_valid && !rd_rx) || deliver;
        next_st.par_err  = (st.par_err && !w1c[ST_PAR_ERR]) || (deliver && st.rx_pbad);
        next_st.frm_err  = (st.frm_err && !w1c[ST_FRM_ERR]) || (deliver && !st.rx_s2);
        next_st.ovr_err  = (st.ovr_err && !w1c[ST_OVR_ERR]) ||
                           (deliver && st.rx_valid && !rd_rx);
        next_st.bcc_err  = st.bcc_err && !w1c[ST_BCC_ERR];
        next_st.bcc_ok   = st.bcc_ok && !w1c[ST_BCC_OK];
        if (deliver) begin
            next_st.rx_data = st.rx_shift;
            unique case (st.rx_msg)
                MSG_NONE: begin
                    if (st.rx_shift == CH_STX) begin
                        next_st.rx_msg = MSG_BODY;
                        next_st.rx_bcc = 8'h00;
                    end
                end
                MSG_BODY: begin
                    next_st.rx_bcc = st.rx_bcc ^ st.rx_shift;
                    if (st.rx_shift == CH_ETX) begin
                        next_st.rx_msg = MSG_BCC;
                    end
                end
                MSG_BCC: begin
                    next_st.rx_msg = MSG_NONE;
                    if (st.rx_shift == st.rx_bcc) begin
                        next_st.bcc_ok = 1'b1;
                    end else begin
                        next_st.bcc_err = 1'b1;
                    end
                end
            endcase
        end

        // Read data is prepared in the setup phase so it leaves a flop
        if (setup) begin
            next_st.err = !reg_known(paddr);
            unique case (paddr)
                REG_CTRL:   next_st.rdata = {30'h0, st.ctrl};
                REG_STATUS: next_st.rdata = {24'h0, status};
                REG_TXDATA: next_st.rdata = {24'h0, st.tx_bcc};
                REG_RXDATA: next_st.rdata = {24'h0, st.rx_data};
                REG_CONFIG: next_st.rdata = {st.sw_s2 != st.sw_act || st.st_s2 != st.st_act,
                                             3'h0, st.st_s2, 2'h0, st.sw_s2,
                                             4'h0, st.st_act, 2'h0, st.sw_act};
                default:    next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st          <= '0;
            st.rx_s1    <= 1'b1;
            st.rx_s2    <= 1'b1;
            st.ctrl     <= CTRL_RST;
            st.tx_st    <= TX_IDLE;
            st.tx_line  <= 1'b1;
            st.rx_st    <= RX_IDLE;
            st.rx_msg   <= MSG_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.rdata;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && st.err;
    assign ser_tx  = st.tx_line;
    assign ser_de  = st.tx_de;
endmodule

// file: sim/msp_port_checker_props.sv
// Concurrent checks on the serial port pins and bus
`timescale 1ns/10ps
module msp_port_checker
    import msp_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  station_number,
    input wire logic        ser_tx,
    input wire logic        ser_de
);
    logic [16:0] de_cnt;
    logic [3:0]  stn_q;
    logic [2:0]  stn_age;
    logic        acc;
    assign acc = psel && penable;
    // Saturating, so slow rates never wrap the count
    always_ff @(posedge core_clk) begin
        if (rst || !ser_de) begin
            de_cnt <= '0;
        end else if (de_cnt != '1) begin
            de_cnt <= de_cnt + 17'h1;
        end
        stn_q <= station_number;
        if (rst || station_number != stn_q) begin
            stn_age <= '0;
        end else if (stn_age != 3'h7) begin
            stn_age <= stn_age + 3'h1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_ready_zero_wait: assert property (acc |-> pready)
        else $error("pready missing in access phase");
    chk_bus_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("bus answer without select");
    chk_unmapped_err: assert property (acc && !pwrite && paddr > REG_CONFIG |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_line_idle: assert property (!ser_de |-> ser_tx)
        else $error("line not high while idle");
    chk_start_low: assert property ($rose(ser_de) |-> !ser_tx)
        else $error("character without start bit");
    chk_start_width: assert property (ser_de && de_cnt < 17'h1770 |-> !ser_tx)
        else $error("start bit too short");
    chk_stop_high: assert property ($fell(ser_de) |-> ser_tx && $past(ser_tx))
        else $error("character not ended by stop bit");
    chk_char_length: assert property ($fell(ser_de) |-> de_cnt > 17'hdea8)
        else $error("character shorter than nine bits");
    chk_cfg_station: assert property (
        acc && !pwrite && paddr == REG_CONFIG && stn_age == 3'h7
        |-> prdata[27:24] == station_number)
        else $error("station pins not shown");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> ser_tx && !ser_de)
        else $error("line driven during reset");
    cover property ($rose(ser_de));
    cover property ($fell(ser_de));
    cover property (acc && pslverr);
endmodule
bind msp_serial_port msp_port_checker msp_port_checker_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .station_number(station_number), .ser_tx(ser_tx), .ser_de(ser_de)
);

// file: sim/msp_host_model.sv
// Host computer model driving the unit receive line
`timescale 1ns/10ps
module msp_host_model
    import msp_pkg::*;
(
    input  wire logic core_clk,
    output logic      ser_rx
);
    localparam int BT = (int'(DIV_FAST) + 1) * OVS;
    // Single unit on the line, so its number is unique
    localparam int UNITS = 1;
    initial ser_rx = 1'b1;
    task automatic send(input logic [7:0] d, input logic seven, input logic par,
                        input logic odd, input logic bad, input logic two);
        logic p;
        int   n;
        begin
            n = seven ? 7 : 8;
            p = ^(seven ? {1'b0, d[6:0]} : d) ^ odd ^ bad;
            @(posedge core_clk);
            ser_rx <= 1'b0;
            repeat (BT) @(posedge core_clk);
            for (int i = 0; i < n; i++) begin
                ser_rx <= d[i];
                repeat (BT) @(posedge core_clk);
            end
            if (par) begin
                ser_rx <= p;
                repeat (BT) @(posedge core_clk);
            end
            ser_rx <= 1'b1;
            repeat (two ? 2 * BT : BT) @(posedge core_clk);
        end
    endtask
endmodule

// file: sim/tb_top.sv
// Bench for the multidrop serial port
`timescale 1ns/10ps
module tb_top
    import msp_pkg::*;
;
    localparam int BT = (int'(DIV_FAST) + 1) * OVS;
    logic        core_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [5:0]  sw;
    logic [3:0]  stn;
    logic        ser_rx;
    logic        ser_tx;
    logic        ser_de;
    logic [31:0] rd;
    logic        er;
    int          fail_count;
    int          samples_checked;
    always #2 core_clk = ~core_clk;
    msp_serial_port msp_serial_port_inst (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_format_switch_bank(sw), .station_number(stn), .ser_rx(ser_rx),
        .ser_tx(ser_tx), .ser_de(ser_de)
    );
    msp_host_model msp_host_model_inst (.core_clk(core_clk), .ser_rx(ser_rx));
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        begin
            @(posedge core_clk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (pready !== 1'b1 && n < 64);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            cmp("pready", 32'h1, {31'h0, pready});
        end
    endtask
    task automatic do_rst(input logic [5:0] s, input logic [3:0] st);
        @(posedge core_clk);
        sw <= s;
        stn <= st;
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    // Samples every bit mid-cell, start bit first
    task automatic watch_tx(input logic [11:0] bits, input int n);
        int k;
        begin
            k = 0;
            while (ser_tx !== 1'b0 && k < 20000) begin
                @(posedge core_clk);
                k++;
            end
            cmp("de_on", 32'h1, {31'h0, ser_de});
            repeat (BT / 2) @(posedge core_clk);
            for (int i = 0; i < n; i++) begin
                cmp("tx_bit", {31'h0, bits[i]}, {31'h0, ser_tx});
                repeat (BT) @(posedge core_clk);
            end
            cmp("de_off", 32'h0, {31'h0, ser_de});
        end
    endtask
    task automatic t_regs();
        apb(1'b0, REG_CTRL, 32'h0, rd, er);
        cmp("ctrl_reset", 32'h3, rd);
        apb(1'b1, REG_CTRL, 32'h0, rd, er);
        apb(1'b0, REG_CTRL, 32'h0, rd, er);
        cmp("ctrl_rw", 32'h0, rd & 32'h3);
        apb(1'b1, REG_CTRL, 32'h3, rd, er);
        apb(1'b0, 12'h014, 32'h0, rd, er);
        cmp("unmapped_err", 32'h1, {31'h0, er});
        cmp("unmapped_data", 32'h0, rd);
    endtask
    task automatic t_cfg();
        apb(1'b0, REG_CONFIG, 32'h0, rd, er);
        cmp("config", 32'h0f190f19, rd & 32'h8f3f0f3f);
    endtask
    task automatic t_duplex7();
        fork
            apb(1'b1, REG_TXDATA, 32'hc1, rd, er);
            watch_tx(12'h282, 10);
            msp_host_model_inst.send(8'h43, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        join
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        cmp("status7", 32'h2, rd & 32'h7f);
        apb(1'b0, REG_RXDATA, 32'h0, rd, er);
        cmp("rx7", 32'h43, rd & 32'hff);
    endtask
    // Pins move but the running setup must not
    task automatic t_relatch();
        @(posedge core_clk);
        sw <= 6'h14;
        stn <= 4'h0;
        repeat (8) @(posedge core_clk);
        apb(1'b0, REG_CONFIG, 32'h0, rd, er);
        cmp("config_pend", 32'h80140f19, rd & 32'h8f3f0f3f);
        do_rst(6'h14, 4'h0);
        apb(1'b0, REG_CONFIG, 32'h0, rd, er);
        cmp("config_new", 32'h00140014, rd & 32'h8f3f0f3f);
    endtask
    task automatic t_duplex8();
        fork
            apb(1'b1, REG_TXDATA, 32'h5a, rd, er);
            watch_tx(12'heb4, 12);
            msp_host_model_inst.send(8'h3c, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
        join
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        cmp("status8", 32'h6, rd & 32'h7f);
        apb(1'b0, REG_RXDATA, 32'h0, rd, er);
        cmp("rx8", 32'h3c, rd & 32'hff);
        apb(1'b1, REG_STATUS, 32'h4, rd, er);
        apb(1'b0, REG_STATUS, 32'h0, rd, er);
        cmp("status_clr", 32'h0, rd & 32'h7f);
    endtask
    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        sw = 6'h19;
        stn = 4'hf;
        fail_count = 0;
        samples_checked = 0;
        do_rst(6'h19, 4'hf);
        t_regs();
        t_cfg();
        t_duplex7();
        t_relatch();
        t_duplex8();
        tally_and_finish();
    end
    // Two characters at the fast rate take about 150k cycles
    initial begin
        repeat (400000) @(posedge core_clk);
        fail_count++;
        tally_and_finish();
    end
endmodule
